// >>> rtl/gpa_defines.vh
// register map, field positions, reset values and mode codes for the six-bit port
// included by every design file of the port; definitions only
// Notes on behaviour
// - six pins, upper two bits absent
// - direction one: driver off, pin input
// - direction zero: drive output latch value
// - pin three input only, direction reads one
// - data reads pins, writes go latch
// - writes are read-modify-write into latch
// - pin three reads zero as reset pin
// - direction still governs analog pins
// - analog-selected pins zero to two read zero
// - crystal modes force direction five, four
// - data, direction, config bits seven, six read zero
// - reset sets direction and analog select
`ifndef GPA_DEFINES_VH
`define GPA_DEFINES_VH

`define GPA_ADDR_W 4
`define GPA_ADDR_DATA 4'h0
`define GPA_ADDR_DIR 4'h1
`define GPA_ADDR_ANALOG_PIN_SELECT 4'h2
`define GPA_ADDR_CFG 4'h3

`define GPA_PIN_N 6
`define GPA_PIN_THREE 3
`define GPA_DIR_RESET 6'h3f
`define GPA_ANALOG_PIN_SELECT_RESET 8'hff
`define GPA_LATCH_RESET 6'h00

`define GPA_CFG_OSC_LSB 0
`define GPA_CFG_OSC_MSB 2
`define GPA_CFG_EXTERNAL_RESET_PIN_ENABLE_BIT 3
`define GPA_CFG_RESET 4'h0

`define GPA_OSC_CRYSTAL_LP 3'h0
`define GPA_OSC_CRYSTAL_XT 3'h1
`define GPA_OSC_CRYSTAL_HS 3'h2
`define GPA_OSC_INTERNAL 3'h4

`define GPA_AN_PIN0 0
`define GPA_AN_PIN1 1
`define GPA_AN_PIN2 2
`define GPA_AN_PIN4 3

`endif

// >>> rtl/gpa_pin_sync.v
// three-stage synchroniser for the six port pins
// assumes pins are asynchronous to i_ref_clk; output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "gpa_defines.vh"
module gpa_pin_sync (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire [`GPA_PIN_N-1:0] i_pin,
    output reg [`GPA_PIN_N-1:0] o_level
);
    reg [`GPA_PIN_N-1:0] stage1;
    reg [`GPA_PIN_N-1:0] stage2;
    reg [`GPA_PIN_N-1:0] stage3;
    genvar g;

    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            stage1 <= 6'h00;
            stage2 <= 6'h00;
            stage3 <= 6'h00;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // per-pin agreement filter
    generate
        for (g = 0; g < `GPA_PIN_N; g = g + 1) begin : gen_agree
            always @(posedge i_ref_clk) begin
                if (!i_rstn) begin
                    o_level[g] <= 1'b0;
                end else if (stage2[g] == stage3[g]) begin
                    o_level[g] <= stage3[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> rtl/gpa_read_mask.v
// digital read path: masks analog-selected pins zero to two and the reset-pin case
// assumes levels are already synchronised; purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "gpa_defines.vh"
module gpa_read_mask (
    input wire [`GPA_PIN_N-1:0] i_level,
    input wire [7:0] i_analog_pin_select,
    input wire i_external_reset_pin_enable,
    output wire [`GPA_PIN_N-1:0] o_digital
);
    wire [`GPA_PIN_N-1:0] analog_pins;

    assign analog_pins = {2'b00, 1'b0, i_analog_pin_select[`GPA_AN_PIN2], i_analog_pin_select[`GPA_AN_PIN1], i_analog_pin_select[`GPA_AN_PIN0]};

    assign o_digital = i_level & ~analog_pins & ~({5'h00, i_external_reset_pin_enable} << `GPA_PIN_THREE);
endmodule
`default_nettype wire

// >>> rtl/gpa_port.v
// six-bit general purpose port: direction, output latch, analog select, config
// assumes a single-cycle register port master; pins resolved outside from output enables
`timescale 1ns/100ps
`default_nettype none
`include "gpa_defines.vh"
module gpa_port (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire [`GPA_ADDR_W-1:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire [`GPA_PIN_N-1:0] i_pin,
    output reg [`GPA_PIN_N-1:0] o_pin,
    output wire [`GPA_PIN_N-1:0] o_pin_oen,
    output wire [7:0] o_analog_select
);
    reg [`GPA_PIN_N-1:0] out_latch;
    reg [`GPA_PIN_N-1:0] direction;
    reg [7:0] analog_pin_select;
    reg [3:0] config_reg;
    reg [7:0] next_rdata;
    wire [`GPA_PIN_N-1:0] pin_level;
    wire [`GPA_PIN_N-1:0] digital_read;
    wire [`GPA_PIN_N-1:0] dir_view;
    wire [2:0] osc_mode;
    wire external_reset_pin_enable;
    wire crystal_mode;

    function is_crystal;
        input [2:0] mode;
        begin
            is_crystal = (mode == `GPA_OSC_CRYSTAL_LP) || (mode == `GPA_OSC_CRYSTAL_XT) ||
                (mode == `GPA_OSC_CRYSTAL_HS);
        end
    endfunction

    gpa_pin_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_pin(i_pin),
        .o_level(pin_level)
    );

    gpa_read_mask u_mask (
        .i_level(pin_level),
        .i_analog_pin_select(analog_pin_select),
        .i_external_reset_pin_enable(external_reset_pin_enable),
        .o_digital(digital_read)
    );

    assign osc_mode = config_reg[`GPA_CFG_OSC_MSB:`GPA_CFG_OSC_LSB];
    assign external_reset_pin_enable = config_reg[`GPA_CFG_EXTERNAL_RESET_PIN_ENABLE_BIT];
    assign crystal_mode = is_crystal(osc_mode);
    assign o_analog_select = analog_pin_select;

    assign dir_view = direction | 6'h08 | (crystal_mode ? 6'h30 : 6'h00);

    // analog pins still under direction
    // active-low enable: low means driving
    assign o_pin_oen = dir_view;

    // drive latch when output
    // a data write reaches the pin in the same cycle as the latch
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_pin <= 6'h00;
        end else if (i_wr && i_addr == `GPA_ADDR_DATA) begin
            o_pin <= i_wdata[5:0] & 6'h37;
        end else begin
            o_pin <= out_latch & 6'h37;
        end
    end

    // reset sets direction, analog select
    // latch keeps its content over reset; zero only at first reset of simulation would be arbitrary
    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            direction <= `GPA_DIR_RESET;
            analog_pin_select <= `GPA_ANALOG_PIN_SELECT_RESET;
            config_reg <= `GPA_CFG_RESET;
        end else if (i_wr) begin
            case (i_addr)
                `GPA_ADDR_DIR: begin
                    direction <= i_wdata[5:0] | 6'h08;
                end
                `GPA_ADDR_ANALOG_PIN_SELECT: begin
                    analog_pin_select <= i_wdata;
                end
                `GPA_ADDR_CFG: begin
                    config_reg <= i_wdata[3:0];
                end
                default: begin
                    direction <= direction;
                end
            endcase
        end
    end

    // pin levels merged with new data
    // byte write: every writable bit comes from i_wdata, unwritable pin three keeps the read level
    always @(posedge i_ref_clk) begin
        if (i_wr && i_addr == `GPA_ADDR_DATA) begin
            out_latch <= (i_wdata[5:0] & 6'h37) | (digital_read & 6'h08);
        end
    end

    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `GPA_ADDR_DATA: next_rdata = {2'b00, digital_read};
            `GPA_ADDR_DIR: next_rdata = {2'b00, dir_view};
            `GPA_ADDR_ANALOG_PIN_SELECT: next_rdata = analog_pin_select;
            `GPA_ADDR_CFG: next_rdata = {4'h0, config_reg};
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// >>> sim/gpa_port_assertions.sv
// checker on the port's register and pin relations
// assumes the single-cycle register port master
`timescale 1ns/100ps
`default_nettype none
module gpa_port_chk (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire [5:0] o_pin,
    input wire [5:0] o_pin_oen,
    input wire [7:0] o_analog_select
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    a_dir_drives_oen: assert property (i_wr && i_addr == 4'h1 |=> o_pin_oen[3:0] == ($past(i_wdata[3:0]) | 4'h8))
        else $error("driver enable does not follow direction");
    a_pin_three_off: assert property (o_pin_oen[3])
        else $error("pin three driven");
    a_dir_three_one: assert property (i_rd && i_addr == 4'h1 |=> o_rdata[3])
        else $error("direction bit three read zero");
    a_upper_bits_zero: assert property (i_rd && i_addr < 4'h2 |=> o_rdata[7:6] == 2'h0)
        else $error("upper bits not zero");
    a_latch_drive: assert property (i_wr && i_addr == 4'h0 |=> o_pin == ($past(i_wdata[5:0]) & 6'h37))
        else $error("latch not driven");
    a_analog_reads_zero: assert property (i_rd && i_addr == 4'h0 |=> (o_rdata[2:0] & o_analog_select[2:0]) == 3'h0)
        else $error("analog pin read nonzero");
    a_analog_pin_select_write: assert property (i_wr && i_addr == 4'h2 |=> o_analog_select == $past(i_wdata))
        else $error("analog select not written");
    a_idle_rdata: assert property (!i_rd || i_addr > 4'h3 |=> o_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule
bind gpa_port gpa_port_chk chk_u (.i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pin,
    .o_pin_oen, .o_analog_select);
`default_nettype wire

// >>> sim/gpa_pin_model.sv
// outside world on the six pins
// assumes active-low enables; the outside drives only released pins
`timescale 1ns/100ps
`default_nettype none
module gpa_pin_model (
    input wire logic [5:0] i_drv,
    input wire logic [5:0] i_oen,
    input wire logic [5:0] i_ext,
    output wire logic [5:0] o_level
);
    assign o_level = (i_oen & i_ext) | (~i_oen & i_drv);
endmodule
`default_nettype wire

// >>> sim/six_bit_gpio_port_a_tb_top.sv
// bench: register port tasks and pin scenarios
// assumes 10 MHz clock and the pin model
`timescale 1ns/100ps
`default_nettype none
module six_bit_gpio_port_a_tb_top;
    logic clk = 0, rstn = 0, wr = 0, rd = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0;
    logic [5:0] ext = 0;
    wire [7:0] rdata, asel;
    wire [5:0] drv, oen, lvl;
    int fails = 0, compares = 0;
    gpa_port dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_pin(lvl), .o_pin(drv), .o_pin_oen(oen), .o_analog_select(asel));
    gpa_pin_model pins_u (.i_drv(drv), .i_oen(oen), .i_ext(ext), .o_level(lvl));
    initial forever #50 clk = ~clk;
    task chk(input string n, input [7:0] s, input [7:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr_reg(input [3:0] a, input [7:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_reg(input [3:0] a, input [7:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk("rdata", rdata, e);
    endtask
    // pins pass a three-stage synchroniser
    task pins(input [5:0] v);
        ext <= v;
        repeat (6) @(posedge clk);
    endtask
    task t_reset;
        rd_reg(4'h1, 8'h3f);
        rd_reg(4'h2, 8'hff);
        chk("oen", {2'h0, oen}, 8'h3f);
    endtask
    task t_dir_latch;
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h3, 8'h04);
        wr_reg(4'h1, 8'hc0);
        rd_reg(4'h1, 8'h08);
        chk("oen", {2'h0, oen}, 8'h08);
        pins(6'h08);
        wr_reg(4'h0, 8'hff);
        #1 chk("pin", {2'h0, drv}, 8'h37);
        pins(6'h08);
        rd_reg(4'h0, 8'h3f);
        wr_reg(4'h3, 8'h0c);
        rd_reg(4'h0, 8'h37);
    endtask
    task t_analog;
        wr_reg(4'h3, 8'h04);
        wr_reg(4'h2, 8'h07);
        rd_reg(4'h0, 8'h38);
        chk("oen", {2'h0, oen}, 8'h08);
    endtask
    task t_osc;
        for (int i = 0; i < 3; i++) begin
            wr_reg(4'h3, i[7:0]);
            rd_reg(4'h1, 8'h38);
        end
        wr_reg(4'h3, 8'h04);
    endtask
    task t_input;
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h1, 8'h3f);
        pins(6'h15);
        rd_reg(4'h0, 8'h15);
        wr_reg(4'h9, 8'hff);
        rd_reg(4'h9, 8'h00);
    endtask
    task t_rst2;
        @(posedge clk);
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        rd_reg(4'h1, 8'h3f);
        rd_reg(4'h2, 8'hff);
    endtask
    task summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        t_reset;
        t_dir_latch;
        t_analog;
        t_osc;
        t_input;
        t_rst2;
        summarize;
    end
    // run needs under 200 cycles
    initial begin
        #100000;
        fails++;
        summarize;
    end
endmodule
`default_nettype wire
